// ===== core/line_maint.v
// E1 per-channel maintenance: loss, alarm, pattern, sequence check, loopback.
// Overview of operation
// - Declare loss after 32 or 2048 quiet pulse intervals, by criteria bit.
// - Clear loss after 32 good intervals from a pulse, density and zero-run checked.
// - Loss indicator high while declared; declaration raises a maskable interrupt.
// - Equalizer off uses fixed 800 mVpp declare, clear 200 mVpp higher.
// - Equalizer on takes declare level from code 0..10; other codes reserved.
// - Hardware mode forces equalizer off and fixed threshold only.
// - During loss, rx substitute bit sends all ones and master clock to system.
// - During loss, tx substitute bit sends all ones on line, master timed.
// - Loss detection and indicator keep working in every loopback mode.
// - Alarm detection only while clock recovery enabled; result in status bit.
// - Criteria 0: alarm on two blocks of 512 under 3 zeros; clear likewise.
// - Criteria 1: alarm on one 512-bit block under 3 zeros; clear likewise.
// - Pattern timed by transmit clock, or master clock when select bit set.
// - Pattern field: 00 normal or zeros, 01 ones, 10 sequence.
// - Hardware mode takes pattern selection from two pins, same codes.
// - Generate 2^15-1 sequence msb first, inverted when invert bit set.
// - Sync set at 6 or fewer errors per 64-bit window, cleared above 6.
// - Sync changes latch sticky bit by edge select; irq while sticky and enabled.
// - Count received sequence errors in 16 bits when error select is 00.
// - Analog loop routes transmit into receive while line stays driven.
// - Hardware loop pins 01 select analog loopback.
// - Hardware loop pins 10 select digital loopback.
// - Hardware loop pins 11 select remote loopback.
`timescale 1ns/1ps
`default_nettype none
`include "line_maint_defs.vh"
module line_maint_chan (
  input wire clk_i,
  input wire rst_i,
  input wire hw_mode_i,
  input wire [7:0] ctrl0_i,
  input wire [11:0] ctrl1_i,
  input wire sticky_clr_i,
  input wire cnt_clr_i,
  input wire [1:0] pat_pins_i,
  input wire [1:0] loop_pins_i,
  input wire tx_tick_i,
  input wire ref_tick_i,
  input wire rx_tick_i,
  input wire tx_data_i,
  input wire rx_above_decl_i,
  input wire rx_above_clr_i,
  input wire rx_data_i,
  input wire ref_clk_lvl_i,
  input wire rec_clk_lvl_i,
  output reg loss_q,
  output reg loss_irq_q,
  output reg ais_q,
  output reg sync_q,
  output reg sticky_q,
  output reg [15:0] err_cnt_q,
  output reg [1:0] loop_q,
  output reg [4:0] level_q,
  output reg line_data_q,
  output reg sys_data_q,
  output reg sys_clk_q
);
  // ctrl0: 0 criteria, 1 rx subst, 2 tx subst, 3 pat clk, 5:4 pattern, 6 invert, 7 cdr enable.
  // ctrl1: 4:0 level code, 5 eq on, 6 edge select, 7 irq en, 8 analog loop,
  // 9 digital loop, 10 remote loop, 11 error select low bit (bit 11 with 0 above).
  wire crit = ctrl0_i[0];
  wire pclk = ctrl0_i[3];
  wire eq_on = ctrl1_i[5] & ~hw_mode_i;
  wire [1:0] pat = hw_mode_i ? pat_pins_i : ctrl0_i[5:4];
  wire pat_tick = pclk ? ref_tick_i : tx_tick_i;
  reg [14:0] lfsr_q;
  reg [14:0] chk_q;
  reg [11:0] quiet_q;
  reg [5:0] good_q;
  reg [5:0] marks_q;
  reg [4:0] zrun_q;
  reg [9:0] blk_q;
  reg [1:0] zc_q;
  reg [1:0] bad_blk_q;
  reg [1:0] ok_blk_q;
  reg [6:0] win_q;
  reg [6:0] errs_q;
  reg sync_d;
  reg [1:0] loop_d;
  reg pat_bit;
  wire [11:0] decl_n = crit ? `LOS_N_LONG : `LOS_N_SHORT;
  wire gen_bit = lfsr_q[14] ^ ctrl0_i[6];
  wire chk_err = rx_data_i ^ ctrl0_i[6] ^ (chk_q[14] ^ chk_q[13]);
  wire blk_end = (blk_q == `AIS_BLOCK - 10'h001);
  // The block's last bit is not in zc_q yet, so it is counted in here.
  wire few_zero = (zc_q < `AIS_ZMIN - 2'h1) || (zc_q == `AIS_ZMIN - 2'h1 && rx_data_i);
  wire win_end = (win_q == `PRBS_WIN - 7'h01);
  always @* begin
    loop_d = `LOOP_NONE;
    if (hw_mode_i) begin
      loop_d = loop_pins_i;
    end else if (ctrl1_i[8]) begin
      loop_d = `LOOP_ANALOG;
    end else if (ctrl1_i[9]) begin
      loop_d = `LOOP_DIGITAL;
    end else if (ctrl1_i[10]) begin
      loop_d = `LOOP_REMOTE;
    end
    case (pat)
      `PAT_NORMAL: pat_bit = pclk ? 1'b0 : tx_data_i;
      `PAT_ONES: pat_bit = 1'b1;
      `PAT_PRBS: pat_bit = gen_bit;
      default: pat_bit = tx_data_i;
    endcase
    sync_d = sync_q;
    if (win_end) begin
      sync_d = ((errs_q + {6'h00, chk_err}) <= `PRBS_ERR_MAX);
    end
  end
  always @(posedge clk_i) begin
    if (rst_i) begin
      loss_q <= 1'b0;
      loss_irq_q <= 1'b0;
      ais_q <= 1'b0;
      sync_q <= 1'b0;
      sticky_q <= 1'b0;
      err_cnt_q <= 16'h0000;
      loop_q <= `LOOP_NONE;
      level_q <= `LEVEL_FIXED;
      line_data_q <= 1'b0;
      sys_data_q <= 1'b0;
      sys_clk_q <= 1'b0;
      lfsr_q <= 15'h7fff;
      chk_q <= 15'h0000;
      quiet_q <= 12'h000;
      good_q <= 6'h00;
      marks_q <= 6'h00;
      zrun_q <= 5'h00;
      blk_q <= 10'h000;
      zc_q <= 2'h0;
      bad_blk_q <= 2'h0;
      ok_blk_q <= 2'h0;
      win_q <= 7'h00;
      errs_q <= 7'h00;
    end else begin
      loop_q <= loop_d;
      level_q <= (eq_on && ctrl1_i[4:0] <= `LEVEL_MAX_CODE) ? ctrl1_i[4:0] : `LEVEL_FIXED;
      loss_irq_q <= 1'b0;
      // Loss runs on the receive path in every loop mode, so no loop term gates it.
      if (rx_tick_i) begin
        if (rx_above_decl_i) begin
          quiet_q <= 12'h000;
        end else if (quiet_q != decl_n) begin
          quiet_q <= quiet_q + 12'h001;
        end
        if (!loss_q && !rx_above_decl_i && quiet_q == decl_n - 12'h001) begin
          loss_q <= 1'b1;
          loss_irq_q <= ctrl1_i[7] | 1'b1;
        end
        zrun_q <= rx_above_clr_i ? 5'h00 : (zrun_q == `LOS_ZRUN_MAX ? zrun_q : zrun_q + 5'h01);
        if (!loss_q || (good_q == 6'h00 && !rx_above_clr_i) ||
            (zrun_q == `LOS_ZRUN_MAX - 5'h01 && !rx_above_clr_i)) begin
          good_q <= 6'h00;
          marks_q <= 6'h00;
        end else if (good_q == `LOS_M - 6'h01) begin
          good_q <= 6'h00;
          marks_q <= 6'h00;
          if ((marks_q + {5'h00, rx_above_clr_i}) >= `LOS_MARK_MIN) begin
            loss_q <= 1'b0;
            quiet_q <= 12'h000;
          end
        end else begin
          good_q <= good_q + 6'h01;
          marks_q <= marks_q + {5'h00, rx_above_clr_i};
        end
        if (ctrl0_i[7]) begin
          blk_q <= blk_end ? 10'h000 : blk_q + 10'h001;
          zc_q <= blk_end ? 2'h0 : ((!rx_data_i && zc_q != `AIS_ZMIN) ? zc_q + 2'h1 : zc_q);
          if (blk_end) begin
            bad_blk_q <= few_zero ? bad_blk_q + {1'b0, bad_blk_q != 2'h2} : 2'h0;
            ok_blk_q <= few_zero ? 2'h0 : ok_blk_q + {1'b0, ok_blk_q != 2'h2};
            if (few_zero && (crit || bad_blk_q != 2'h0)) begin
              ais_q <= 1'b1;
            end else if (!few_zero && (crit || ok_blk_q != 2'h0)) begin
              ais_q <= 1'b0;
            end
          end
        end else begin
          ais_q <= 1'b0;
          blk_q <= 10'h000;
          zc_q <= 2'h0;
        end
        chk_q <= {chk_q[13:0], rx_data_i ^ ctrl0_i[6]};
        win_q <= win_end ? 7'h00 : win_q + 7'h01;
        errs_q <= win_end ? 7'h00 : errs_q + {6'h00, chk_err};
        sync_q <= sync_d;
        if (ctrl1_i[11] == 1'b0 && chk_err && err_cnt_q != 16'hffff) begin
          err_cnt_q <= err_cnt_q + 16'h0001;
        end
        sys_data_q <= (loss_q && ctrl0_i[1]) ? 1'b1 : rx_data_i;
      end
      if (cnt_clr_i && !(rx_tick_i && chk_err)) begin
        err_cnt_q <= 16'h0000;
      end
      // Set wins over clear so a sync change in the clearing cycle is kept.
      if (rx_tick_i && (sync_d != sync_q) && (sync_d || ctrl1_i[6])) begin
        sticky_q <= 1'b1;
      end else if (sticky_clr_i) begin
        sticky_q <= 1'b0;
      end
      sys_clk_q <= (loss_q && ctrl0_i[1]) ? ref_clk_lvl_i : rec_clk_lvl_i;
      if (loss_q && ctrl0_i[2]) begin
        if (ref_tick_i) begin
          line_data_q <= 1'b1;
        end
      end else if (pat_tick) begin
        lfsr_q <= {lfsr_q[13:0], lfsr_q[14] ^ lfsr_q[13]};
        line_data_q <= pat_bit;
      end
    end
  end
endmodule
module line_maint (
  input wire clk_i,
  input wire rst_i,
  input wire [4:0] adr_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  input wire [3:0] sel_i,
  input wire we_i,
  input wire cyc_i,
  input wire stb_i,
  output reg ack_o,
  input wire hw_mode_i,
  input wire [3:0] pat_pins_i,
  input wire [3:0] loop_pins_i,
  input wire [1:0] tx_tick_i,
  input wire ref_tick_i,
  input wire [1:0] rx_tick_i,
  input wire [1:0] tx_data_i,
  input wire [1:0] rx_above_decl_i,
  input wire [1:0] rx_above_clr_i,
  input wire [1:0] rx_data_i,
  input wire ref_clk_lvl_i,
  input wire [1:0] rec_clk_lvl_i,
  output reg [1:0] loss_indicator_pin_o,
  output reg irq_o,
  output reg [1:0] line_data_o,
  output reg [1:0] sys_data_o,
  output reg [1:0] sys_clk_o,
  output reg [3:0] loop_mode_o
);
  reg [7:0] ctrl0_q [0:1];
  reg [11:0] ctrl1_q [0:1];
  reg [1:0] sticky_clr_q;
  reg [1:0] cnt_clr_q;
  reg [1:0] loss_seen_q;
  wire [1:0] loss;
  wire [1:0] loss_irq;
  wire [1:0] ais;
  wire [1:0] sync;
  wire [1:0] sticky;
  wire [31:0] cnt;
  wire [3:0] loop;
  wire [9:0] level;
  wire [1:0] ldat;
  wire [1:0] sdat;
  wire [1:0] sclk;
  wire ch = adr_i[4];
  wire [3:0] reg_sel = adr_i[3:0];
  wire req = cyc_i && stb_i && !ack_o;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : chan
      line_maint_chan u_chan (
        .clk_i(clk_i), .rst_i(rst_i), .hw_mode_i(hw_mode_i),
        .ctrl0_i(ctrl0_q[g]), .ctrl1_i(ctrl1_q[g]),
        .sticky_clr_i(sticky_clr_q[g]), .cnt_clr_i(cnt_clr_q[g]),
        .pat_pins_i(pat_pins_i[2*g+1:2*g]), .loop_pins_i(loop_pins_i[2*g+1:2*g]),
        .tx_tick_i(tx_tick_i[g]), .ref_tick_i(ref_tick_i), .rx_tick_i(rx_tick_i[g]),
        .tx_data_i(tx_data_i[g]), .rx_above_decl_i(rx_above_decl_i[g]),
        .rx_above_clr_i(rx_above_clr_i[g]), .rx_data_i(rx_data_i[g]),
        .ref_clk_lvl_i(ref_clk_lvl_i), .rec_clk_lvl_i(rec_clk_lvl_i[g]),
        .loss_q(loss[g]), .loss_irq_q(loss_irq[g]), .ais_q(ais[g]), .sync_q(sync[g]),
        .sticky_q(sticky[g]), .err_cnt_q(cnt[16*g+15:16*g]), .loop_q(loop[2*g+1:2*g]),
        .level_q(level[5*g+4:5*g]), .line_data_q(ldat[g]), .sys_data_q(sdat[g]),
        .sys_clk_q(sclk[g])
      );
    end
  endgenerate
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
      ctrl0_q[0] <= 8'h80;
      ctrl0_q[1] <= 8'h80;
      ctrl1_q[0] <= 12'h000;
      ctrl1_q[1] <= 12'h000;
      sticky_clr_q <= 2'h0;
      cnt_clr_q <= 2'h0;
      loss_seen_q <= 2'h0;
      irq_o <= 1'b0;
      loss_indicator_pin_o <= 2'h0;
      line_data_o <= 2'h0;
      sys_data_o <= 2'h0;
      sys_clk_o <= 2'h0;
      loop_mode_o <= 4'h0;
    end else begin
      ack_o <= req;
      sticky_clr_q <= 2'h0;
      cnt_clr_q <= 2'h0;
      loss_indicator_pin_o <= loss;
      line_data_o <= ldat;
      sys_data_o <= sdat;
      sys_clk_o <= sclk;
      loop_mode_o <= loop;
      // Loss interrupt bit is masked by ctrl1 bit 7, the irq enable it shares with sticky; set wins over the read clear.
      loss_seen_q <= (loss_seen_q & ~(req && !we_i && reg_sel == `ADR_STAT ? (ch ? 2'h2 : 2'h1) :
        2'h0)) | (loss_irq & {ctrl1_q[1][7], ctrl1_q[0][7]});
      irq_o <= |(sticky & {ctrl1_q[1][7], ctrl1_q[0][7]}) || |loss_seen_q;
      dat_o <= 32'h00000000;
      if (req && we_i) begin
        if (reg_sel == `ADR_CTRL0 && sel_i[0]) begin
          ctrl0_q[ch] <= dat_i[7:0];
        end
        if (reg_sel == `ADR_CTRL1 && sel_i[0]) begin
          ctrl1_q[ch][7:0] <= dat_i[7:0];
        end
        if (reg_sel == `ADR_CTRL1 && sel_i[1]) begin
          ctrl1_q[ch][11:8] <= dat_i[11:8];
        end
        if (reg_sel == `ADR_STAT && sel_i[0] && dat_i[3]) begin
          sticky_clr_q[ch] <= 1'b1;
        end
        if (reg_sel == `ADR_ERRCNT) begin
          cnt_clr_q[ch] <= 1'b1;
        end
      end else if (req) begin
        case (reg_sel)
          `ADR_CTRL0: dat_o <= {24'h000000, ctrl0_q[ch]};
          `ADR_CTRL1: dat_o <= {20'h00000, ctrl1_q[ch]};
          `ADR_STAT: dat_o <= {19'h00000, level[5*ch+:5], loop[2*ch+:2], 1'b0,
            loss_seen_q[ch], sticky[ch], sync[ch], ais[ch], loss[ch]};
          `ADR_ERRCNT: dat_o <= {16'h0000, cnt[16*ch+:16]};
          default: dat_o <= 32'h00000000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ===== core/line_maint_defs.vh
// Constants for the E1 channel maintenance block.
`ifndef LINE_MAINT_DEFS_VH
`define LINE_MAINT_DEFS_VH
`define ADR_CTRL0 4'h0
`define ADR_CTRL1 4'h1
`define ADR_STAT 4'h2
`define ADR_ERRCNT 4'h3
`define CHAN_STRIDE 4'h4
`define LOS_N_SHORT 12'h020
`define LOS_N_LONG 12'h800
`define LOS_M 6'h20
`define LOS_ZRUN_MAX 5'h10
`define LOS_MARK_MIN 6'h04
`define AIS_BLOCK 10'h200
`define AIS_ZMIN 2'h3
`define PRBS_WIN 7'h40
`define PRBS_ERR_MAX 7'h06
`define PAT_NORMAL 2'h0
`define PAT_ONES 2'h1
`define PAT_PRBS 2'h2
`define LOOP_NONE 2'h0
`define LOOP_ANALOG 2'h1
`define LOOP_DIGITAL 2'h2
`define LOOP_REMOTE 2'h3
`define ERRSEL_PRBS 2'h0
`define LEVEL_MAX_CODE 5'h0a
`define LEVEL_FIXED 5'h1f
`endif

// ===== verif/line_maint_sva.sv
// Port-level checker for the channel maintenance block.
`timescale 1ns/1ps
`default_nettype none
module line_maint_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic hw_mode_i,
  input wire logic [3:0] pat_pins_i,
  input wire logic [3:0] loop_pins_i,
  input wire logic [1:0] rx_tick_i,
  input wire logic [1:0] rx_above_decl_i,
  input wire logic [1:0] rx_above_clr_i,
  input wire logic [1:0] loss_indicator_pin_o,
  input wire logic irq_o,
  input wire logic [1:0] line_data_o,
  input wire logic [3:0] loop_mode_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Loopback feeds the detector from elsewhere, so the quiet count restarts there; the mark count restarts only while the indicator is low.
  logic [5:0] quiet_q;
  logic [2:0] marks_q;
  always_ff @(posedge clk_i) begin
    if (rst_i || loop_mode_o[1:0] != 2'h0) begin
      quiet_q <= 6'h00;
    end else if (rx_tick_i[0]) begin
      quiet_q <= rx_above_decl_i[0] ? 6'h00 : (quiet_q == 6'h3f ? quiet_q : quiet_q + 6'h01);
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || !loss_indicator_pin_o[0]) begin
      marks_q <= 3'h0;
    end else if (rx_tick_i[0] && rx_above_clr_i[0] && marks_q != 3'h7) begin
      marks_q <= marks_q + 3'h1;
    end
  end
  a_ack_one_cycle: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_ack_after_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acknowledged in one cycle");
  a_ack_has_req: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  a_reset_clean: assert property ($fell(rst_i) |-> !ack_o && !irq_o &&
    loss_indicator_pin_o == 2'h0 && loop_mode_o == 4'h0 && line_data_o == 2'h0)
    else $error("outputs not clear after reset");
  a_loop_pin_map: assert property ((hw_mode_i && $stable(loop_pins_i)) [*3]
    |-> loop_mode_o == loop_pins_i)
    else $error("loop mode does not follow pins");
  a_ones_pattern: assert property ((hw_mode_i && pat_pins_i[1:0] == 2'h1) [*8]
    |-> line_data_o[0])
    else $error("all ones pattern missing");
  a_quiet_declare: assert property ($rose(loss_indicator_pin_o[0]) &&
    loop_mode_o[1:0] == 2'h0 |-> quiet_q >= 6'h20)
    else $error("loss declared too early");
  a_clear_marks: assert property ($fell(loss_indicator_pin_o[0]) &&
    loop_mode_o[1:0] == 2'h0 |-> marks_q >= 3'h4)
    else $error("loss cleared without enough marks");
endmodule
bind line_maint line_maint_sva line_maint_sva_inst (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o,
  .hw_mode_i, .pat_pins_i, .loop_pins_i, .rx_tick_i, .rx_above_decl_i, .rx_above_clr_i,
  .loss_indicator_pin_o, .irq_o, .line_data_o, .loop_mode_o);
`default_nettype wire

// ===== verif/line_model.sv
// Line and clock side model: bit strobes, received pulses and clock levels.
`timescale 1ns/1ps
`default_nettype none
module line_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] mode_i,
  input wire logic [1:0] loop_i,
  output logic [1:0] rx_tick_o,
  output logic [1:0] tx_tick_o,
  output logic ref_tick_o,
  output logic [1:0] pulse_o,
  output logic [1:0] tx_data_o,
  output logic ref_lvl_o,
  output logic [1:0] rec_lvl_o
);
  logic [1:0] ph_q;
  logic [1:0] bit_q;
  logic pulse;
  always_ff @(posedge clk_i) begin
    ph_q <= rst_i ? 2'h0 : ph_q + 2'h1;
    bit_q <= rst_i ? 2'h0 : (ph_q == 2'h0 ? bit_q + 2'h1 : bit_q);
  end
  // Mode 0 is a dead line, 1 all ones, 2 one zero in four bits, 3 the block's own line output.
  assign pulse = mode_i == 2'h1 || (mode_i == 2'h2 && bit_q != 2'h0);
  assign rx_tick_o = {2{ph_q == 2'h0}};
  assign tx_tick_o = {2{ph_q == 2'h1}};
  assign ref_tick_o = ph_q == 2'h2;
  assign pulse_o = mode_i == 2'h3 ? loop_i : {2{pulse}};
  assign tx_data_o = {2{bit_q[0]}};
  assign ref_lvl_o = ph_q[1];
  assign rec_lvl_o = {2{ph_q[0]}};
endmodule
`default_nettype wire

// ===== verif/testbench.sv
// Self-checking bench for the channel maintenance block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_i = 0, rst_i = 1, we_i = 0, cyc_i = 0, stb_i = 0, hw_mode_i = 0, irq_o, ref_tick_i;
  logic [4:0] adr_i = 5'h00;
  logic [31:0] dat_i = 32'h0, dat_o, d;
  logic [3:0] sel_i = 4'hf, pat_pins_i = 4'h0, loop_pins_i = 4'h0, loop_mode_o;
  logic [1:0] mode = 2'h1, tx_tick_i, rx_tick_i, tx_data_i, pulse, rec_clk_lvl_i;
  logic [1:0] loss_indicator_pin_o, line_data_o, sys_data_o, sys_clk_o;
  logic ack_o, ref_clk_lvl_i;
  int failures = 0, n_compared = 0, n;
  always #4 clk_i = ~clk_i;
  line_model line_model_inst (.clk_i(clk_i), .rst_i(rst_i), .mode_i(mode), .loop_i(line_data_o),
    .rx_tick_o(rx_tick_i), .tx_tick_o(tx_tick_i), .ref_tick_o(ref_tick_i), .pulse_o(pulse),
    .tx_data_o(tx_data_i), .ref_lvl_o(ref_clk_lvl_i), .rec_lvl_o(rec_clk_lvl_i));
  line_maint line_maint_inst (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
    .dat_o(dat_o), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .hw_mode_i(hw_mode_i), .pat_pins_i(pat_pins_i), .loop_pins_i(loop_pins_i),
    .tx_tick_i(tx_tick_i), .ref_tick_i(ref_tick_i), .rx_tick_i(rx_tick_i),
    .tx_data_i(tx_data_i), .rx_above_decl_i(pulse), .rx_above_clr_i(pulse),
    .rx_data_i(pulse), .ref_clk_lvl_i(ref_clk_lvl_i), .rec_clk_lvl_i(rec_clk_lvl_i),
    .loss_indicator_pin_o(loss_indicator_pin_o), .irq_o(irq_o), .line_data_o(line_data_o),
    .sys_data_o(sys_data_o), .sys_clk_o(sys_clk_o), .loop_mode_o(loop_mode_o));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // The request is held until ack is sampled high, then dropped for a cycle.
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; dat_i <= wd;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 20);
    if (ack_o !== 1'b1) begin
      failures++;
      $display("CHECK FAILED at %0t: bus request not acknowledged", $time);
    end
    d = dat_o;
    cyc_i <= 0; stb_i <= 0; we_i <= 0;
  endtask
  task automatic wait_loss(input logic v);
    n = 0;
    while (loss_indicator_pin_o[0] !== v && n < 9000) begin
      @(posedge clk_i);
      n++;
    end
    if (loss_indicator_pin_o[0] !== v) begin
      failures++;
      $display("CHECK FAILED at %0t: loss indicator wait timed out", $time);
    end
  endtask
  task automatic t_regs;
    wb(0, 5'h00, 0); chk(d, 32'h80);
    wb(0, 5'h11, 0); chk(d, 32'h0);
    wb(1, 5'h05, 32'hff); wb(0, 5'h05, 0); chk(d, 32'h0);
    wb(1, 5'h01, 32'h25); wb(0, 5'h02, 0); chk(d & 32'h1f00, 32'h0500);
    wb(1, 5'h01, 32'h2b); wb(0, 5'h02, 0); chk(d & 32'h1f00, 32'h1f00);
  endtask
  task automatic t_loss;
    wb(1, 5'h01, 32'h80); mode <= 2'h0; wait_loss(1);
    chk(32'(n >= 120 && n <= 150), 1);
    // The interrupt output sits one register stage behind the indicator.
    @(posedge clk_i);
    chk(32'(irq_o), 1);
    chk(32'(loss_indicator_pin_o), 32'h3);
    wb(0, 5'h02, 0); chk(d & 32'h1f01, 32'h1f01);
    mode <= 2'h1; wait_loss(0);
    chk(32'(n >= 120 && n <= 150), 1);
  endtask
  task automatic t_alarm;
    // Block edges run free, so three blocks are waited out before each criteria 0 verdict and two before the criteria 1 one.
    repeat (6200) @(posedge clk_i);
    wb(0, 5'h02, 0); chk(d & 32'h2, 32'h2);
    mode <= 2'h2; repeat (6200) @(posedge clk_i);
    wb(0, 5'h02, 0); chk(d & 32'h2, 32'h0);
    wb(1, 5'h00, 32'h81); mode <= 2'h1; repeat (4130) @(posedge clk_i);
    wb(0, 5'h02, 0); chk(d & 32'h2, 32'h2);
    wb(1, 5'h00, 32'h80);
  endtask
  task automatic t_subst;
    wb(1, 5'h00, 32'h86); mode <= 2'h0; wait_loss(1);
    repeat (8) @(posedge clk_i);
    chk(32'(sys_data_o), 32'h1);
    chk(32'(line_data_o[0]), 1);
    // Two register stages delay a clock level by half its four-cycle period.
    repeat (4) begin
      @(posedge clk_i);
      chk(32'(sys_clk_o), 32'({rec_clk_lvl_i[1], ~ref_clk_lvl_i}));
    end
    mode <= 2'h1; wait_loss(0); wb(1, 5'h00, 32'h80);
  endtask
  task automatic t_hw;
    hw_mode_i <= 1; pat_pins_i <= 4'h5;
    for (int i = 1; i < 5; i++) begin
      loop_pins_i <= {2{i[1:0]}}; repeat (10) @(posedge clk_i);
      chk(32'(loop_mode_o), 32'(loop_pins_i));
      chk(32'(line_data_o), 32'h3);
    end
    hw_mode_i <= 0; pat_pins_i <= 4'h0;
  endtask
  task automatic t_prbs;
    wb(0, 5'h02, 0); chk(d & 32'h1f, 32'h12);
    repeat (2) @(posedge clk_i);
    chk(32'(irq_o), 0);
    wb(1, 5'h00, 32'ha0); mode <= 2'h3;
    repeat (1000) @(posedge clk_i);
    wb(1, 5'h03, 0); repeat (400) @(posedge clk_i);
    wb(0, 5'h03, 0); chk(d, 32'h0);
    wb(0, 5'h02, 0); chk(d & 32'hc, 32'hc);
    chk(32'(irq_o), 1);
    mode <= 2'h1; repeat (600) @(posedge clk_i);
    wb(0, 5'h03, 0); chk(32'(d >= 130 && d <= 155), 1);
    wb(0, 5'h02, 0); chk(d & 32'h4, 32'h0);
    wb(1, 5'h00, 32'h80);
  endtask
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    t_regs;
    t_loss;
    t_alarm;
    t_subst;
    t_hw;
    t_prbs;
    results;
  end
  // Scenarios need about 20000 cycles.
  initial begin
    repeat (60000) @(posedge clk_i);
    failures++;
    results;
  end
endmodule
`default_nettype wire
